/* File: testbench.sv */
// Self-checking bench for the touch tracker status registers.
// Drives the AXI4-Lite slave, tracker and playback inputs directly.
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import ttsr_pkg::*;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [15:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic [31:0] s_axi_wdata = '0;
   logic [3:0] s_axi_wstrb = '0;
   logic multi_touch_extended = 1'h0, media_read_step = 1'h0;
   ttsr_track_upd_s [TTSR_POINTS-1:0] track_upd = '0;
   ttsr_ptr_load_s media_read_load = '0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic media_queue_empty;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata, media_queue_write_pointer;
   int fail_count = 0;
   int samples_checked = 0;
   // Clock at 125 MHz
   always #4 aclk = ~aclk;
   ttsr_regs i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .multi_touch_extended, .track_upd,
      .media_read_load, .media_read_step, .media_queue_write_pointer, .media_queue_empty);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude;
      $display("compares %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Write one word and judge the response
   task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
      input logic [1:0] er);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
      chk({30'h0, s_axi_bresp}, {30'h0, er});
      @(posedge aclk);
   endtask
   // Read one word and judge data and response
   task automatic rd(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'h0;
      chk(s_axi_rdata, ed);
      chk({30'h0, s_axi_rresp}, {30'h0, er});
      @(posedge aclk);
   endtask
   task automatic t_reset;
      for (int i = 0; i < 7; i++) rd(16'h7000 + 16'(4 * i), 32'h0, TTSR_RESP_OKAY);
   endtask
   // All five points updated, extra points kept only in extended mode
   task automatic t_track(input logic ext);
      multi_touch_extended <= ext;
      repeat (2) @(posedge aclk);
      for (int i = 0; i < TTSR_POINTS; i++)
         track_upd[i] <= '{1'h1, 16'hc0d0 + 16'(i), 8'h50 + 8'(i)};
      @(posedge aclk);
      track_upd <= '0;
      @(posedge aclk);
      for (int i = 0; i < TTSR_POINTS; i++)
         rd(16'h7000 + 16'(4 * i), (ext || i == 0) ? {16'hc0d0 + 16'(i), 8'h00,
            8'h50 + 8'(i)} : 32'h0, TTSR_RESP_OKAY);
   endtask
   // Read-only writes ignored, write pointer stored by byte, bad address refused
   task automatic t_write;
      wr(16'h7000, 32'hffff_ffff, 4'hf, TTSR_RESP_OKAY);
      rd(16'h7000, 32'hc0d0_0050, TTSR_RESP_OKAY);
      wr(16'h7014, 32'hffff_ffff, 4'hf, TTSR_RESP_OKAY);
      rd(16'h7014, 32'h0, TTSR_RESP_OKAY);
      wr(16'h7018, 32'h1234_5678, 4'hf, TTSR_RESP_OKAY);
      chk(media_queue_write_pointer, 32'h1234_5678);
      chk({31'h0, media_queue_empty}, 32'h0);
      wr(16'h7018, 32'h0000_00ab, 4'h1, TTSR_RESP_OKAY);
      chk(media_queue_write_pointer, 32'h1234_56ab);
      wr(16'h7020, 32'h1, 4'hf, TTSR_RESP_SLVERR);
      rd(16'h6ffc, 32'h0, TTSR_RESP_SLVERR);
   endtask
   // Read pointer loaded, stepped up to the write pointer and held there
   task automatic t_media;
      media_read_load <= '{1'h1, 32'h1234_56a9};
      @(posedge aclk);
      media_read_load <= '0;
      rd(16'h7014, 32'h1234_56a9, TTSR_RESP_OKAY);
      chk({31'h0, media_queue_empty}, 32'h0);
      repeat (3) begin
         media_read_step <= 1'h1;
         @(posedge aclk);
      end
      media_read_step <= 1'h0;
      @(posedge aclk);
      chk({31'h0, media_queue_empty}, 32'h1);
      rd(16'h7014, 32'h1234_56ab, TTSR_RESP_OKAY);
   endtask
   // Reset in mid-run returns every register and the write pointer to zero
   task automatic t_rerun;
      aresetn <= 1'h0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      chk(media_queue_write_pointer, 32'h0);
      chk({31'h0, media_queue_empty}, 32'h1);
      t_reset();
   endtask
   // Main sequence
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      t_reset();
      t_track(1'h1);
      t_track(1'h0);
      t_write();
      t_media();
      t_rerun();
      conclude();
   end
   // Watchdog cuts a hang short
   initial begin
      #40000;
      fail_count++;
      conclude();
   end
endmodule
`default_nettype wire

/* File: ttsr_media_ptr.sv */
// Media queue read pointer with load and byte advance, stopping at the write pointer.
// Assumes load and step come from the playback engine on the same clock.
`default_nettype none
module ttsr_media_ptr (
   input wire logic aclk,
   input wire logic aresetn,
   input wire ttsr_pkg::ttsr_ptr_load_s load,
   input wire logic step,
   input wire logic [31:0] wr_ptr,
   output logic [31:0] rd_ptr,
   output logic empty
);
   import ttsr_pkg::*;

   logic [31:0] next_rd_ptr;

   // Load wins over a step; a step into an empty queue is dropped
   always_comb begin
      next_rd_ptr = rd_ptr;
      if (load.valid) begin
         next_rd_ptr = load.addr;
      end else if (step && (rd_ptr != wr_ptr)) begin
         next_rd_ptr = rd_ptr + 32'h0000_0001;
      end
   end

   // Pointer register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_ptr <= TTSR_RST_MQ_READ;
      end else begin
         rd_ptr <= next_rd_ptr;
      end
   end

   // Empty flag tracks the pointers as they will stand
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         empty <= 1'b1;
      end else begin
         empty <= (next_rd_ptr == wr_ptr);
      end
   end
endmodule
`default_nettype wire

/* File: ttsr_pkg.sv */
// Constants, types and field layout for the touch tracker status registers.
// Assumes one 125 MHz clock and an AXI4-Lite master with 32-bit data.
`default_nettype none
package ttsr_pkg;
   // Register byte offsets
   localparam logic [15:0] TTSR_OFS_PRIMARY = 16'h7000;
   localparam logic [15:0] TTSR_OFS_SECOND = 16'h7004;
   localparam logic [15:0] TTSR_OFS_THIRD = 16'h7008;
   localparam logic [15:0] TTSR_OFS_FOURTH = 16'h700c;
   localparam logic [15:0] TTSR_OFS_FIFTH = 16'h7010;
   localparam logic [15:0] TTSR_OFS_MQ_READ = 16'h7014;
   localparam logic [15:0] TTSR_OFS_MQ_WRITE = 16'h7018;
   // Field positions
   localparam int TTSR_TAG_LSB = 0;
   localparam int TTSR_TAG_W = 8;
   localparam int TTSR_VAL_LSB = 16;
   localparam int TTSR_VAL_W = 16;
   // Reset values
   localparam logic [31:0] TTSR_RST_TRACK = 32'h0000_0000;
   localparam logic [31:0] TTSR_RST_MQ_READ = 32'h0000_0000;
   localparam logic [31:0] TTSR_RST_MQ_WRITE = 32'h0000_0000;
   // Number of touch points
   localparam int TTSR_POINTS = 5;
   // AXI responses
   localparam logic [1:0] TTSR_RESP_OKAY = 2'h0;
   localparam logic [1:0] TTSR_RESP_SLVERR = 2'h2;

   // Decoded register selector
   typedef enum logic [2:0] {
      TTSR_SEL_TRACK0 = 3'h0,
      TTSR_SEL_TRACK1 = 3'h1,
      TTSR_SEL_TRACK2 = 3'h2,
      TTSR_SEL_TRACK3 = 3'h3,
      TTSR_SEL_TRACK4 = 3'h4,
      TTSR_SEL_MQ_READ = 3'h5,
      TTSR_SEL_MQ_WRITE = 3'h6,
      TTSR_SEL_NONE = 3'h7
   } ttsr_sel_e;

   // One tracker update from the coprocessor
   typedef struct packed {
      logic valid;
      logic [TTSR_VAL_W-1:0] value;
      logic [TTSR_TAG_W-1:0] tag;
   } ttsr_track_upd_s;

   // Media queue read pointer load from the playback engine
   typedef struct packed {
      logic valid;
      logic [31:0] addr;
   } ttsr_ptr_load_s;
endpackage
`default_nettype wire

/* File: ttsr_regs.sv */
// Touch tracker and media queue status registers behind an AXI4-Lite slave.
// Assumes a single clock aclk and a synchronous active-low reset aresetn;
// tracker updates, the extended-mode level and the playback pointer inputs
// all come from logic on aclk, so none of them is synchronised here.
`default_nettype none
module ttsr_regs #(
   parameter int ADDR_W = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address channel
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data channel
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response channel
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address channel
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data channel
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Capacitive touch engine mode and coprocessor tracker results
   input wire logic multi_touch_extended,
   input wire ttsr_pkg::ttsr_track_upd_s [ttsr_pkg::TTSR_POINTS-1:0] track_upd,
   // Media playback engine
   input wire ttsr_pkg::ttsr_ptr_load_s media_read_load,
   input wire logic media_read_step,
   output logic [31:0] media_queue_write_pointer,
   output logic media_queue_empty
);
   import ttsr_pkg::*;

   // Map a byte address onto a register selector
   function automatic ttsr_sel_e decode(input logic [ADDR_W-1:0] addr);
      logic [15:0] a;
      a = 16'h0000;
      a[ADDR_W-1:0] = addr;
      a[1:0] = 2'h0;
      unique case (a)
         TTSR_OFS_PRIMARY: decode = TTSR_SEL_TRACK0;
         TTSR_OFS_SECOND: decode = TTSR_SEL_TRACK1;
         TTSR_OFS_THIRD: decode = TTSR_SEL_TRACK2;
         TTSR_OFS_FOURTH: decode = TTSR_SEL_TRACK3;
         TTSR_OFS_FIFTH: decode = TTSR_SEL_TRACK4;
         TTSR_OFS_MQ_READ: decode = TTSR_SEL_MQ_READ;
         TTSR_OFS_MQ_WRITE: decode = TTSR_SEL_MQ_WRITE;
         default: decode = TTSR_SEL_NONE;
      endcase
   endfunction

   // Merge write data into an old word under the byte strobes
   function automatic logic [31:0] merge(
      input logic [31:0] old_word,
      input logic [31:0] new_word,
      input logic [3:0] strb
   );
      logic [31:0] m;
      m = old_word;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            m[8*b +: 8] = new_word[8*b +: 8];
         end
      end
      return m;
   endfunction

   logic [31:0] track_word [TTSR_POINTS];
   logic [31:0] media_rd_ptr;
   logic [31:0] next_media_queue_write_pointer;
   logic [ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_fire;
   ttsr_sel_e wr_sel;
   ttsr_sel_e rd_sel;
   logic [31:0] rd_word;
   logic rd_ok;

   // Tracker slots; the first point is always live, the rest need extended mode
   for (genvar i = 0; i < TTSR_POINTS; i++) begin : g_slot
      ttsr_track_slot u_slot (
         .aclk(aclk),
         .aresetn(aresetn),
         .enable((i == 0) ? 1'b1 : multi_touch_extended),
         .upd(track_upd[i]),
         .word(track_word[i])
      );
   end

   // Media queue read pointer, bounded by the write pointer as it will stand,
   // so the empty flag moves on the same edge as a host write
   ttsr_media_ptr u_media_ptr (
      .aclk(aclk),
      .aresetn(aresetn),
      .load(media_read_load),
      .step(media_read_step),
      .wr_ptr(next_media_queue_write_pointer),
      .rd_ptr(media_rd_ptr),
      .empty(media_queue_empty)
   );

   // Write address channel: take once, hold until the response is accepted
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         aw_addr <= '0;
      end else if (s_axi_awready && s_axi_awvalid) begin
         s_axi_awready <= 1'b0;
         aw_addr <= s_axi_awaddr;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_awready <= 1'b1;
      end
   end

   // Write data channel: independent of the address, same release point
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_wready <= 1'b1;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (s_axi_wready && s_axi_wvalid) begin
         s_axi_wready <= 1'b0;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_wready <= 1'b1;
      end
   end

   // Both halves held and no response out yet: perform the write now
   assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   assign wr_sel = decode(aw_addr);

   // Write response; read-only registers accept and discard the data
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= TTSR_RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (wr_sel == TTSR_SEL_NONE) ? TTSR_RESP_SLVERR : TTSR_RESP_OKAY;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Host-owned media queue write pointer, the only writable word
   always_comb begin
      next_media_queue_write_pointer = media_queue_write_pointer;
      if (wr_fire && (wr_sel == TTSR_SEL_MQ_WRITE)) begin
         next_media_queue_write_pointer = merge(media_queue_write_pointer, w_data, w_strb);
      end
   end

   // Write pointer register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         media_queue_write_pointer <= TTSR_RST_MQ_WRITE;
      end else begin
         media_queue_write_pointer <= next_media_queue_write_pointer;
      end
   end

   // Read selection; the write pointer is write-only and reads as zero
   assign rd_sel = decode(s_axi_araddr);
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_ok = 1'b1;
      unique case (rd_sel)
         TTSR_SEL_TRACK0: rd_word = track_word[0];
         TTSR_SEL_TRACK1: rd_word = track_word[1];
         TTSR_SEL_TRACK2: rd_word = track_word[2];
         TTSR_SEL_TRACK3: rd_word = track_word[3];
         TTSR_SEL_TRACK4: rd_word = track_word[4];
         TTSR_SEL_MQ_READ: rd_word = media_rd_ptr;
         TTSR_SEL_MQ_WRITE: rd_word = 32'h0000_0000;
         TTSR_SEL_NONE: rd_ok = 1'b0;
      endcase
   end

   // Read address channel: one read in flight
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
      end else if (s_axi_arready && s_axi_arvalid) begin
         s_axi_arready <= 1'b0;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_arready <= 1'b1;
      end
   end

   // Read data: captured at the address handshake, held until accepted
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= TTSR_RESP_OKAY;
      end else if (s_axi_arready && s_axi_arvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_ok ? TTSR_RESP_OKAY : TTSR_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* File: ttsr_regs_monitor.sv */
// Checker for the touch tracker status register slave.
// Sees only the top ports; bound into every ttsr_regs instance.
`default_nettype none
module ttsr_regs_monitor
   import ttsr_pkg::*;
#(
   parameter int ADDR_W = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic multi_touch_extended,
   input wire logic [31:0] media_queue_write_pointer
);
   logic [ADDR_W-1:0] rd_addr;
   logic ext_d;
   logic rd_off;
   // Remember address and mode of the read in flight
   always_ff @(posedge aclk) begin
      ext_d <= multi_touch_extended;
      if (s_axi_arvalid && s_axi_arready) begin
         rd_addr <= s_axi_araddr;
         rd_off <= !multi_touch_extended && !ext_d;
      end
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_rd_lat;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   property p_unmap;
      s_axi_rvalid && (rd_addr < 16'h7000 || rd_addr > 16'h701b)
         |-> s_axi_rresp == TTSR_RESP_SLVERR && s_axi_rdata == 32'h0;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
   property p_rsvd;
      s_axi_rvalid && rd_addr inside {[16'h7000:16'h7010]} |-> s_axi_rdata[15:8] == 8'h00;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved byte not zero");
   property p_ext_off;
      s_axi_rvalid && rd_off && rd_addr inside {[16'h7004:16'h7010]} |-> s_axi_rdata == 32'h0;
   endproperty
   a_ext_off: assert property (p_ext_off) else $error("extra point filled");
   property p_b_lat;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
   endproperty
   a_b_lat: assert property (p_b_lat) else $error("write answer late");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
   property p_wp;
      $changed(media_queue_write_pointer) |-> s_axi_bvalid;
   endproperty
   a_wp: assert property (p_wp) else $error("write pointer moved alone");
   c_ext: cover property (s_axi_rvalid && rd_off);
   c_err: cover property (s_axi_bvalid && s_axi_bresp == TTSR_RESP_SLVERR);
   c_wp: cover property ($changed(media_queue_write_pointer));
endmodule
bind ttsr_regs ttsr_regs_monitor #(.ADDR_W(ADDR_W)) i_mon (.aclk, .aresetn, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
   .s_axi_rready, .multi_touch_extended, .media_queue_write_pointer);
`default_nettype wire

/* File: ttsr_track_slot.sv */
// One tracker register: tag in the low byte, tracking value in the top half.
// Assumes updates come from coprocessor logic on the same clock.
`default_nettype none
module ttsr_track_slot (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic enable,
   input wire ttsr_pkg::ttsr_track_upd_s upd,
   output logic [31:0] word
);
   import ttsr_pkg::*;

   // Hold the latest update; a disabled slot is held at zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         word <= TTSR_RST_TRACK;
      end else if (!enable) begin
         word <= TTSR_RST_TRACK;
      end else if (upd.valid) begin
         word <= TTSR_RST_TRACK;
         word[TTSR_TAG_LSB +: TTSR_TAG_W] <= upd.tag;
         word[TTSR_VAL_LSB +: TTSR_VAL_W] <= upd.value;
      end
   end
   // Bits 15 to 8 are never written and stay zero
endmodule
`default_nettype wire
